// >>> rtl/adc_params.svh
// Constants of the serial conversion control block
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
`define CMD_BITS 6'h08
`define LEN_BYTE 6'h08
`define LEN_WORD16 6'h10
`define ADDR_STATUS 3'h0
`define ADDR_MODE 3'h1
`define ADDR_CONFIG 3'h2
`define ADDR_DATA 3'h3
`define ADDR_ID 3'h4
`define ADDR_IO 3'h5
`define ADDR_OFFSET 3'h6
`define ADDR_FULLSCALE 3'h7
`define CMD_CREAD_ENTER 8'h5C
`define CMD_CREAD_EXIT 8'h58
`define RESET_ONES 6'h20
`define STAT_RDY_BIT 7
`define MODE_FIELD_MSB 15
`define MODE_FIELD_LSB 13
`define RATE_MSB 3
`define RATE_LSB 0
`define MODE_CONT 3'h0
`define MODE_SINGLE 3'h1
`define MODE_RST 16'h000A
`define MODE_RST_RATE 4'hA
`define CONFIG_RST 16'h0710
`define IO_RST 8'h00
`define CLK_HZ 50000000
`define TICK_CYCLES (`CLK_HZ / 1000000)
`define OSC_UP_US 20'h003E8
`define CONV_PERIODS 2
`define RATE_INTEG 4'h1
`define RATE_SINC4_MAX 4'h5
`define RATE_MSINC3_MAX 4'hA
`define PER_US_1 20'h007D0
`define PER_US_2 20'h00FA0
`define PER_US_3 20'h01F40
`define PER_US_4 20'h03E80
`define PER_US_5 20'h04E20
`define PER_US_6 20'h063A6
`define PER_US_7 20'h0754E
`define PER_US_8 20'h0C74C
`define PER_US_9 20'h0E9E8
`define PER_US_A 20'h0E9E8
`define PER_US_B 20'h13880
`define PER_US_C 20'h186A0
`define PER_US_D 20'h1D4F0
`define PER_US_E 20'h27100
`define PER_US_F 20'h3A8C0
`endif

// >>> rtl/adc_types_pkg.sv
// Types shared by the serial conversion control block
package adc_types_pkg;
   typedef enum logic [1:0] {ST_CMD = 2'h0, ST_WRITE = 2'h1, ST_READ = 2'h3} ser_state_e;
   typedef enum logic [1:0] {CV_OFF = 2'h0, CV_OSC = 2'h1, CV_CONV = 2'h3, CV_RUN = 2'h2} conv_state_e;
   typedef enum logic [1:0] {
      FILT_SINC4 = 2'h0, FILT_INTEG = 2'h1, FILT_MSINC3 = 2'h2, FILT_SINC3AVG = 2'h3
   } filter_e;
   typedef struct packed {
      logic wen;
      logic rw;
      logic [2:0] rs;
      logic cread;
      logic [1:0] spare;
   } cmd_s;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } pins_s;
endpackage : adc_types_pkg

// >>> rtl/pin_sync.sv
// Two-stage synchronisers for the serial pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 3,
   parameter logic [width-1:0] rst_val = '0
) (
   input logic clock,
   input logic rst,
   input logic ce,
   input logic [width-1:0] pins_async,
   output logic [width-1:0] pins_sync
);
   genvar i;
   generate
      for (i = 0; i < width; i++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge clock) begin
            if (rst) begin
               meta_r <= rst_val[i];
               sync_r <= rst_val[i];
            end else if (ce) begin
               meta_r <= pins_async[i];
               sync_r <= meta_r;
            end
         end
         assign pins_sync[i] = sync_r;
      end
   endgenerate
endmodule : pin_sync

// >>> rtl/conv_sequencer.sv
// Conversion timing: oscillator start, update periods, filter choice
`timescale 1ns/1ps
`include "adc_params.svh"
module conv_sequencer import adc_types_pkg::*; #(
   parameter int tick_cycles = `TICK_CYCLES
) (
   input logic clock,
   input logic rst,
   input logic ce,
   input logic soft_rst,
   input logic mode_wr,
   input logic [2:0] mode_field,
   input logic [3:0] rate_code,
   output logic conv_done,
   output logic powered,
   output filter_e filter_sel
);
   function automatic logic [19:0] period_us(input logic [3:0] code);
      case (code)
         4'h1: period_us = `PER_US_1;
         4'h2: period_us = `PER_US_2;
         4'h3: period_us = `PER_US_3;
         4'h4: period_us = `PER_US_4;
         4'h5: period_us = `PER_US_5;
         4'h6: period_us = `PER_US_6;
         4'h7: period_us = `PER_US_7;
         4'h8: period_us = `PER_US_8;
         4'h9: period_us = `PER_US_9;
         4'hB: period_us = `PER_US_B;
         4'hC: period_us = `PER_US_C;
         4'hD: period_us = `PER_US_D;
         4'hE: period_us = `PER_US_E;
         4'hF: period_us = `PER_US_F;
         default: period_us = `PER_US_A;
      endcase
   endfunction : period_us

   conv_state_e st_r, st_nxt;
   logic [19:0] cnt_r, cnt_nxt;
   logic [15:0] tdiv_r;
   wire logic tick = (tdiv_r == 16'(tick_cycles - 1));
   wire logic [19:0] per = period_us(rate_code);
   wire logic at_end = tick && (cnt_r == 20'h00001);

   // -----------------------------------------------
   // Filter selection by rate
   // -----------------------------------------------
   assign filter_sel = (rate_code == `RATE_INTEG) ? FILT_INTEG :
                       (rate_code <= `RATE_SINC4_MAX) ? FILT_SINC4 :
                       (rate_code <= `RATE_MSINC3_MAX) ? FILT_MSINC3 : FILT_SINC3AVG;
   assign conv_done = at_end && (st_r == CV_CONV || st_r == CV_RUN);
   assign powered = (st_r != CV_OFF);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = tick ? cnt_r - 20'h00001 : cnt_r;
      if (soft_rst) begin
         st_nxt = CV_RUN;
         cnt_nxt = period_us(`MODE_RST_RATE);
      end else if (mode_wr) begin
         case (mode_field)
            `MODE_SINGLE: begin
               st_nxt = CV_OSC;
               cnt_nxt = `OSC_UP_US;
            end
            `MODE_CONT: begin
               st_nxt = CV_RUN;
               cnt_nxt = per;
            end
            default: begin
               st_nxt = CV_OFF;
               cnt_nxt = '0;
            end
         endcase
      end else if (at_end) begin
         case (st_r)
            CV_OSC: begin
               st_nxt = CV_CONV;
               cnt_nxt = 20'(per * `CONV_PERIODS);
            end
            CV_CONV: begin
               st_nxt = CV_OFF;
               cnt_nxt = '0;
            end
            CV_RUN: cnt_nxt = per;
            default: st_nxt = CV_OFF;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= CV_RUN;
         cnt_r <= period_us(`MODE_RST_RATE);
         tdiv_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         tdiv_r <= tick ? 16'h0000 : tdiv_r + 16'h0001;
      end
   end

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   a_single_end: assert property (@(posedge clock) disable iff (rst || !ce)
      st_r == CV_CONV && at_end && !soft_rst && !mode_wr |=> st_r == CV_OFF)
      else $error("single conversion did not return to shutdown");
   a_osc_start: assert property (@(posedge clock) disable iff (rst || !ce)
      mode_wr && !soft_rst && mode_field == `MODE_SINGLE
      |=> st_r == CV_OSC && cnt_r == `OSC_UP_US)
      else $error("oscillator start time not loaded");
   a_filter_integ: assert property (@(posedge clock) disable iff (rst)
      rate_code == `RATE_INTEG |-> filter_sel == FILT_INTEG)
      else $error("wrong filter at fastest rate");
   c_single_done: cover property (@(posedge clock) disable iff (rst)
      st_r == CV_CONV && conv_done);
endmodule : conv_sequencer

// >>> rtl/adc_serial_conversion_control.sv
// Serial host interface and conversion sequencing of the converter
`timescale 1ns/1ps
`include "adc_params.svh"
module adc_serial_conversion_control import adc_types_pkg::*; #(
   parameter int width = 24,
   parameter int tick_cycles = `TICK_CYCLES,
   parameter logic [23:0] fs_default = 24'h500000,
   parameter logic [7:0] id_code = 8'h3C
) (
   input logic clock,
   input logic rst,
   input logic ce,
   input logic cs_n,
   input logic sclk,
   input logic din,
   input logic [width-1:0] conv_word,
   output logic dout,
   output logic dout_oe,
   output logic rdy_n,
   output logic cread_active,
   output logic [15:0] mode_word,
   output logic [15:0] config_word,
   output logic [7:0] io_word,
   output logic [width-1:0] offset_word,
   output logic [width-1:0] fullscale_word,
   output logic powered,
   output filter_e filter_sel
);
   // id_code default is an arbitrary value

   function automatic logic [5:0] reg_len(input logic [2:0] rs);
      case (rs)
         `ADDR_MODE, `ADDR_CONFIG: reg_len = `LEN_WORD16;
         `ADDR_DATA, `ADDR_OFFSET, `ADDR_FULLSCALE: reg_len = 6'(width);
         default: reg_len = `LEN_BYTE;
      endcase
   endfunction : reg_len

   // -----------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------
   pins_s raw;
   pins_s syn;
   logic sclk_q_r;
   logic cs_q_r;
   assign raw = {cs_n, sclk, din};

   pin_sync #(
      .width(3),
      .rst_val(3'h6)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .pins_async(raw),
      .pins_sync(syn)
   );

   wire logic rise = !syn.cs_n && syn.sclk && !sclk_q_r;
   wire logic fall = !syn.cs_n && !syn.sclk && sclk_q_r;

   // -----------------------------------------------
   // State
   // -----------------------------------------------
   ser_state_e st_r, st_nxt;
   logic [5:0] bcnt_r, bcnt_nxt;
   logic [5:0] ones_r;
   logic [width-1:0] shin_r, shin_nxt;
   logic [width-1:0] shout_r, shout_nxt;
   logic [width-1:0] data_r;
   logic [width-1:0] offset_r, offset_nxt;
   logic [width-1:0] fs_r, fs_nxt;
   logic [2:0] addr_r, addr_nxt;
   logic [15:0] mode_r, mode_nxt;
   logic [15:0] config_r, config_nxt;
   logic [7:0] io_r, io_nxt;
   logic cread_r, cread_nxt;
   logic rdy_n_r, rdy_n_nxt;
   logic pend_r;
   logic mode_wr, mode_wr_r;
   logic dout_r;
   logic oe_r;
   logic conv_done;
   logic [width-1:0] rd_raw;

   // -----------------------------------------------
   // Decoding
   // -----------------------------------------------
   wire logic [7:0] cmd_byte = {shin_r[6:0], syn.din};
   wire cmd_s cmd = cmd_s'(cmd_byte);
   wire logic [2:0] cmd_rs = cmd.rs;
   wire logic cmd_last = (bcnt_r == `CMD_BITS - 6'h01);
   wire logic last_bit = (bcnt_r == reg_len(addr_r) - 6'h01);
   wire logic [width-1:0] wr_val = {shin_r[width-2:0], syn.din};
   wire logic [width-1:0] rd_word = rd_raw << (6'(width) - reg_len(cmd_rs));
   wire logic [7:0] status_byte = 8'(rdy_n_r) << `STAT_RDY_BIT;
   wire logic wr_ok = (cmd_rs != `ADDR_STATUS) && (cmd_rs != `ADDR_DATA) &&
                      (cmd_rs != `ADDR_ID);
   wire logic ones_hit = rise && syn.din && (ones_r == `RESET_ONES - 6'h01);
   wire logic cmd_take = rise && st_r == ST_CMD && cmd_last && !cread_r;
   wire logic cread_exit = rise && cread_r && cmd_last &&
                           cmd_byte == `CMD_CREAD_EXIT && !rdy_n_r;
   wire logic data_busy = (st_r == ST_READ) && (addr_r == `ADDR_DATA);
   wire logic commit_ok = pend_r && (cread_r || !data_busy);
   wire logic read_done = rise && st_r == ST_READ && last_bit;
   wire logic data_read_done = read_done && addr_r == `ADDR_DATA;
   wire logic out_msb = shout_r[width-1];

   always_comb begin
      case (cmd_rs)
         `ADDR_STATUS: rd_raw = width'(status_byte);
         `ADDR_MODE: rd_raw = width'(mode_r);
         `ADDR_CONFIG: rd_raw = width'(config_r);
         `ADDR_DATA: rd_raw = data_r;
         `ADDR_ID: rd_raw = width'(id_code);
         `ADDR_IO: rd_raw = width'(io_r);
         `ADDR_OFFSET: rd_raw = offset_r;
         default: rd_raw = fs_r;
      endcase
   end

   // -----------------------------------------------
   // Ready flag
   // -----------------------------------------------
   always_comb begin
      rdy_n_nxt = rdy_n_r;
      if (commit_ok) begin
         rdy_n_nxt = 1'b0;
      end else if (conv_done || data_read_done) begin
         rdy_n_nxt = 1'b1;
      end
   end

   // -----------------------------------------------
   // Serial engine
   // -----------------------------------------------
   always_comb begin
      st_nxt = st_r;
      bcnt_nxt = bcnt_r;
      shin_nxt = shin_r;
      shout_nxt = shout_r;
      addr_nxt = addr_r;
      cread_nxt = cread_r;
      mode_nxt = mode_r;
      config_nxt = config_r;
      io_nxt = io_r;
      offset_nxt = offset_r;
      fs_nxt = fs_r;
      mode_wr = 1'b0;
      if (syn.cs_n) begin
         bcnt_nxt = '0;
         if (!cread_r) begin
            st_nxt = ST_CMD;
         end
      end else begin
         if (fall && st_r == ST_READ && bcnt_r != 6'h00) begin
            shout_nxt = shout_r << 1;
         end
         if (rise) begin
            shin_nxt = wr_val;
            bcnt_nxt = bcnt_r + 6'h01;
            case (st_r)
               ST_CMD: begin
                  if (cmd_last) begin
                     bcnt_nxt = '0;
                     if (!cread_r && !cmd.wen) begin
                        addr_nxt = cmd_rs;
                        if (cmd.rw && cmd_rs == `ADDR_DATA && cmd.cread) begin
                           cread_nxt = 1'b1;
                        end else if (cmd.rw) begin
                           st_nxt = ST_READ;
                           shout_nxt = rd_word;
                        end else if (wr_ok) begin
                           st_nxt = ST_WRITE;
                        end
                     end
                  end
               end
               ST_WRITE: begin
                  if (last_bit) begin
                     st_nxt = ST_CMD;
                     bcnt_nxt = '0;
                     case (addr_r)
                        `ADDR_MODE: begin
                           mode_nxt = wr_val[15:0];
                           mode_wr = 1'b1;
                        end
                        `ADDR_CONFIG: config_nxt = wr_val[15:0];
                        `ADDR_IO: io_nxt = wr_val[7:0];
                        `ADDR_OFFSET: offset_nxt = wr_val;
                        default: fs_nxt = wr_val;
                     endcase
                  end
               end
               ST_READ: begin
                  if (last_bit) begin
                     st_nxt = ST_CMD;
                     bcnt_nxt = '0;
                  end
               end
               default: st_nxt = ST_CMD;
            endcase
            if (cread_exit) begin
               cread_nxt = 1'b0;
               st_nxt = ST_CMD;
               bcnt_nxt = '0;
            end
         end
      end
      if (commit_ok && cread_r && !cread_exit) begin
         st_nxt = ST_READ;
         bcnt_nxt = '0;
         shout_nxt = conv_word;
      end
   end

   // -----------------------------------------------
   // Registers
   // -----------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_q_r <= 1'b1;
         cs_q_r <= 1'b1;
         dout_r <= 1'b1;
         oe_r <= 1'b0;
      end else if (ce) begin
         sclk_q_r <= syn.sclk;
         cs_q_r <= syn.cs_n;
         dout_r <= (st_r == ST_READ) ? out_msb : rdy_n_r;
         oe_r <= !syn.cs_n;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || (ce && ones_hit)) begin
         st_r <= ST_CMD;
         bcnt_r <= '0;
         ones_r <= '0;
         shin_r <= '0;
         shout_r <= '0;
         addr_r <= `ADDR_STATUS;
         cread_r <= 1'b0;
         rdy_n_r <= 1'b1;
         pend_r <= 1'b0;
         mode_wr_r <= 1'b0;
         data_r <= '0;
         mode_r <= `MODE_RST;
         config_r <= `CONFIG_RST;
         io_r <= `IO_RST;
         offset_r <= {1'b1, {(width - 1){1'b0}}};
         fs_r <= fs_default[23 -: width];
      end else if (ce) begin
         st_r <= st_nxt;
         bcnt_r <= bcnt_nxt;
         if (rise) begin
            ones_r <= syn.din ? ones_r + 6'h01 : 6'h00;
         end
         shin_r <= shin_nxt;
         shout_r <= shout_nxt;
         addr_r <= addr_nxt;
         cread_r <= cread_nxt;
         rdy_n_r <= rdy_n_nxt;
         pend_r <= conv_done;
         mode_wr_r <= mode_wr;
         if (commit_ok) begin
            data_r <= conv_word;
         end
         mode_r <= mode_nxt;
         config_r <= config_nxt;
         io_r <= io_nxt;
         offset_r <= offset_nxt;
         fs_r <= fs_nxt;
      end
   end

   // -----------------------------------------------
   // Conversion sequencing
   // -----------------------------------------------
   conv_sequencer #(
      .tick_cycles(tick_cycles)
   ) u_seq (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .soft_rst(ones_hit),
      .mode_wr(mode_wr_r),
      .mode_field(mode_r[`MODE_FIELD_MSB:`MODE_FIELD_LSB]),
      .rate_code(mode_r[`RATE_MSB:`RATE_LSB]),
      .conv_done(conv_done),
      .powered(powered),
      .filter_sel(filter_sel)
   );

   assign dout = dout_r;
   assign dout_oe = oe_r;
   assign rdy_n = rdy_n_r;
   assign cread_active = cread_r;
   assign mode_word = mode_r;
   assign config_word = config_r;
   assign io_word = io_r;
   assign offset_word = offset_r;
   assign fullscale_word = fs_r;

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst || !ce);

   a_ones_reset: assert property (ones_hit |=>
      st_r == ST_CMD && !cread_r && bcnt_r == 6'h00 && mode_r == `MODE_RST)
      else $error("interface reset did not restore power-on state");
   a_rdy_low: assert property (commit_ok && !ones_hit |=> !rdy_n_r)
      else $error("ready not low after new word");
   a_rdy_high_read: assert property (data_read_done && !commit_ok |=> rdy_n_r)
      else $error("ready not high after data read");
   a_warn_high: assert property (conv_done |=> rdy_n_r)
      else $error("ready not raised before data update");
   a_data_hold: assert property ($changed(data_r) |-> $past(pend_r) || $past(ones_hit))
      else $error("data word changed without a conversion");
   a_drop_busy: assert property (pend_r && data_busy && !cread_r && !ones_hit
      |=> $stable(data_r))
      else $error("conversion not discarded during data access");
   a_cread_load: assert property (commit_ok && cread_r && !ones_hit && !cread_exit
      |=> st_r == ST_READ && bcnt_r == 6'h00 && shout_r == $past(conv_word))
      else $error("continuous read word not reloaded");
   a_cread_enter: assert property (cmd_take && cmd_byte == `CMD_CREAD_ENTER
      |=> cread_r)
      else $error("continuous read not entered");
   a_cread_exit: assert property (cread_exit && !ones_hit |=> !cread_r && st_r == ST_CMD)
      else $error("continuous read not left");
   a_cmd_decode: assert property (cmd_take && !cmd.wen && cmd.rw && !cmd.cread
      && !ones_hit |=> st_r == ST_READ && addr_r == $past(cmd_rs))
      else $error("command byte not decoded to a read");
   a_frame_msb: assert property (cs_q_r && !syn.cs_n && st_r == ST_READ
      |=> dout_r == $past(out_msb))
      else $error("select edge did not present the MSB");

   c_cread_word: cover property (commit_ok && cread_r);
   c_ones_reset: cover property (ones_hit);
   c_data_read: cover property (data_read_done);
   c_discard: cover property (pend_r && data_busy && !cread_r);
endmodule : adc_serial_conversion_control

// >>> bench/host_model.sv
// Host serial port model driving the converter link
`timescale 1ns/1ps
module host_model (
   input wire logic clock,
   input wire logic dout,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b0;
      sclk = 1'b1;
      din = 1'b0;
   end
   // Din set at the fall, dout taken late in the high phase
   task automatic shift(input logic [31:0] tx, input int nb, output logic [31:0] rx);
      rx = '0;
      for (int i = nb - 1; i >= 0; i--) begin
         @(posedge clock) sclk <= 1'b0;
         din <= tx[i];
         repeat (4) @(posedge clock);
         sclk <= 1'b1;
         repeat (3) @(posedge clock);
         @(negedge clock);
         rx = {rx[30:0], dout};
      end
      @(posedge clock) din <= 1'b0;
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask : shift
   // Select pin moved between frames, settled before return
   task automatic set_select(input logic level);
      @(posedge clock) cs_n <= level;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask : set_select
endmodule : host_model

// >>> bench/adc_serial_conversion_control_tb.sv
// Self-checking bench for the serial conversion control block
`timescale 1ns/1ps
module adc_serial_conversion_control_tb import adc_types_pkg::*;;
   logic clock, rst, ce, cs_n, sclk, din, dout, dout_oe, rdy_n, cread_active, powered;
   logic [23:0] conv_word, offset_word, fullscale_word;
   logic [15:0] mode_word, config_word;
   logic [7:0] io_word;
   logic [31:0] rx;
   filter_e filter_sel;
   int mismatches = 0;
   int tests_run = 0;
   logic [3:0] rates [4] = '{4'h5, 4'h6, 4'hB, 4'h1};
   filter_e fexp [4] = '{FILT_SINC4, FILT_MSINC3, FILT_SINC3AVG, FILT_INTEG};
   host_model host_u (.clock(clock), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
   adc_serial_conversion_control #(.tick_cycles(1)) dut_u (.clock(clock), .rst(rst),
      .ce(ce), .cs_n(cs_n), .sclk(sclk), .din(din), .conv_word(conv_word), .dout(dout),
      .dout_oe(dout_oe), .rdy_n(rdy_n), .cread_active(cread_active), .mode_word(mode_word),
      .config_word(config_word), .io_word(io_word), .offset_word(offset_word),
      .fullscale_word(fullscale_word), .powered(powered), .filter_sel(filter_sel));
   // ----------------
   // Shared tasks
   // ----------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wait_rdy(input int lim, output int n);
      n = 0;
      while (rdy_n !== 1'b0 && n < lim) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
   endtask : wait_rdy
   task automatic end_sim();
      $display("counts tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_regs();
      check({mode_word, config_word}, 32'h000A0710);
      host_u.shift(32'h28A5, 16, rx);
      check(io_word, 8'hA5);
      check({rdy_n, cread_active, dout_oe}, 3'h5);
      host_u.shift(32'h6800, 16, rx);
      check(rx[7:0], 8'hA5);
      $display("test regs done");
   endtask : t_regs
   task automatic t_filter();
      for (int i = 0; i < 4; i++) begin
         host_u.shift({20'h08000, rates[i]}, 24, rx);
         check(filter_sel, fexp[i]);
      end
      $display("test filter done");
   endtask : t_filter
   task automatic t_conv();
      int n;
      wait_rdy(2200, n);
      check({rdy_n, dout}, 2'h0);
      for (int k = 0; k < 2; k++) begin
         host_u.shift(32'h58000000, 32, rx);
         check(rx[23:0], conv_word);
         check(rdy_n, 1'b1);
      end
      $display("test conv done");
   endtask : t_conv
   task automatic t_cread();
      int n;
      host_u.shift(32'h5C, 8, rx);
      check(cread_active, 1'b1);
      wait_rdy(2200, n);
      host_u.set_select(1'b1);
      check(dout_oe, 1'b0);
      host_u.set_select(1'b0);
      check({dout_oe, dout}, {1'b1, conv_word[23]});
      host_u.shift(32'h0, 24, rx);
      check(rx[23:0], conv_word);
      wait_rdy(2200, n);
      host_u.shift(32'h58, 8, rx);
      check(cread_active, 1'b0);
      $display("test cread done");
   endtask : t_cread
   task automatic t_single();
      int n;
      host_u.shift(32'h58000000, 32, rx);
      check(rx[23:0], conv_word);
      check(rdy_n, 1'b1);
      host_u.shift(32'h086001, 24, rx);
      check(powered, 1'b0);
      host_u.shift(32'h082001, 24, rx);
      check(powered, 1'b1);
      wait_rdy(5200, n);
      check(n > 4970 && n < 5010, 1'b1);
      repeat (4) @(negedge clock);
      check(powered, 1'b0);
      host_u.shift(32'h58000000, 32, rx);
      check(rx[23:0], conv_word);
      repeat (300) @(negedge clock);
      check(rdy_n, 1'b1);
      $display("test single done");
   endtask : t_single
   task automatic t_ifreset();
      host_u.shift(32'h28A4, 16, rx);
      host_u.shift(32'h30123456, 32, rx);
      check(offset_word, 24'h123456);
      host_u.shift(32'hFFFFFFFF, 32, rx);
      check({mode_word, io_word, cread_active, rdy_n}, 26'h0002801);
      check(offset_word, 24'h800000);
      check(fullscale_word, 24'h500000);
      repeat (500) @(negedge clock);
      host_u.shift(32'h6800, 16, rx);
      check(rx[15:0], 16'hFF00);
      $display("test ifreset done");
   endtask : t_ifreset
   // ----------------
   // Clock, reset, sequence
   // ----------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      conv_word = 24'h9C3A5E;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      t_regs();
      t_filter();
      t_conv();
      t_cread();
      t_single();
      t_ifreset();
      end_sim();
   end
   initial begin
      repeat (40000) @(posedge clock);
      mismatches++;
      end_sim();
   end
endmodule : adc_serial_conversion_control_tb
